/* File: design/qdw_consts.svh */
/*
  Constants of the quad converter write decoder: frame field positions,
  register-select codes, reset values and frame lengths.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef QDW_CONSTS_SVH
`define QDW_CONSTS_SVH

// ----------------------------------------------------------------------
// Frame lengths
// ----------------------------------------------------------------------
`define QDW_FRAME_BITS       6'h18
`define QDW_FRAME_BITS_CHK   6'h20
`define QDW_BIT_CNT_MAX      6'h21

// ----------------------------------------------------------------------
// Field positions inside the 24-bit command word
// ----------------------------------------------------------------------
`define QDW_RW_BIT           23
`define QDW_CHIP_HI_BIT      22
`define QDW_CHIP_LO_BIT      21
`define QDW_REGSEL_MSB       20
`define QDW_REGSEL_LSB       18
`define QDW_CHSEL_MSB        17
`define QDW_CHSEL_LSB        16
`define QDW_DATA_MSB         15
`define QDW_DATA_LSB         0
`define QDW_SUBSEL_MSB       15
`define QDW_SUBSEL_LSB       13
`define QDW_CTRL_DATA_MSB    12
`define QDW_CLR_EN_BIT       6

// ----------------------------------------------------------------------
// Register-select codes
// ----------------------------------------------------------------------
`define QDW_SEL_DATA         3'h0
`define QDW_SEL_GAIN         3'h2
`define QDW_SEL_GAIN_ALL     3'h3
`define QDW_SEL_OFFSET       3'h4
`define QDW_SEL_OFFSET_ALL   3'h5
`define QDW_SEL_CLEAR        3'h6
`define QDW_SEL_CONTROL      3'h7
`define QDW_SUBSEL_CHAN_CTRL 3'h2

// ----------------------------------------------------------------------
// Reset values and arithmetic
// ----------------------------------------------------------------------
`define QDW_DATA_RST         16'h0000
`define QDW_GAIN_RST         16'hffff
`define QDW_OFFSET_RST       16'h8000
`define QDW_CLEAR_RST        16'h0000
`define QDW_OFFSET_BIAS      19'sh08000
`define QDW_CODE_MAX         19'sh0ffff

`endif

/* File: design/qdw_pkg.sv */
/*
  Types shared by the quad converter write decoder files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package qdw_pkg;
  typedef logic [15:0] qdw_code_t;
  typedef logic [1:0]  qdw_chan_t;
  typedef logic [2:0]  qdw_sel_t;
  typedef logic [12:0] qdw_ctrl_data_t;
  typedef logic [23:0] qdw_word_t;
  typedef logic [5:0]  qdw_bit_cnt_t;
  typedef enum logic {QDW_IDLE, QDW_SHIFT} qdw_rx_state_t;
endpackage

/* File: design/qdw_frame_rx.sv */
/*
  Serial frame receiver: shifts the input bit in on every clock while the
  frame select is low and reports a whole command word when it rises.
  Assumes the clock is the serial clock and inputs are synchronous to it.
*/
`timescale 1ns/1ps
`include "qdw_consts.svh"

module qdw_frame_rx (
  input  wire logic              clk,          // Serial clock
  input  wire logic              rst_n,        // Synchronous reset, active low
  input  wire logic              sync_n,       // Frame select, active low
  input  wire logic              sdin,         // Serial data, MSB first
  input  wire logic              check_en,     // Frame carries a check byte
  output qdw_pkg::qdw_word_t     frame_word,   // Command word of last frame
  output logic                   frame_valid   // One-cycle pulse, whole frame
);
  import qdw_pkg::*;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  qdw_rx_state_t state_reg,  state_next;
  logic [31:0]   shift_reg,  shift_next;
  qdw_bit_cnt_t  cnt_reg,    cnt_next;
  qdw_word_t     word_reg,   word_next;
  logic          valid_reg,  valid_next;
  qdw_bit_cnt_t  expected;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    word_next  = word_reg;
    valid_next = 1'b0;
    expected   = check_en ? `QDW_FRAME_BITS_CHK : `QDW_FRAME_BITS;
    if (!sync_n) begin
      state_next = QDW_SHIFT;
      shift_next = {shift_reg[30:0], sdin};
      if (cnt_reg != `QDW_BIT_CNT_MAX) begin
        cnt_next = cnt_reg + 6'h01;
      end
    end else begin
      unique case (state_reg)
        QDW_IDLE: begin
          cnt_next = 6'h00;
        end
        QDW_SHIFT: begin
          // Short or long frames are dropped here
          valid_next = (cnt_reg == expected);
          word_next  = check_en ? shift_reg[31:8] : shift_reg[23:0];
          state_next = QDW_IDLE;
          cnt_next   = 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= QDW_IDLE;
      shift_reg <= 32'h0000_0000;
      cnt_reg   <= 6'h00;
      word_reg  <= 24'h00_0000;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      word_reg  <= word_next;
      valid_reg <= valid_next;
    end
  end

  assign frame_word  = word_reg;
  assign frame_valid = valid_reg;
endmodule

/* File: design/qdw_out_calc.sv */
/*
  Output code of one channel: data code scaled by the gain trim, then
  shifted by the bias-coded offset trim and clamped to the code range.
  Assumes its inputs are registers of the decoder.
*/
`timescale 1ns/1ps
`include "qdw_consts.svh"

module qdw_out_calc (
  input  wire logic              clk,      // Serial clock
  input  wire logic              rst_n,    // Synchronous reset, active low
  input  qdw_pkg::qdw_code_t     data,     // Channel data code
  input  qdw_pkg::qdw_code_t     gain,     // Gain trim, unsigned
  input  qdw_pkg::qdw_code_t     offset,   // Offset trim, midpoint bias
  output qdw_pkg::qdw_code_t     code      // Corrected code, registered
);
  import qdw_pkg::*;

  qdw_code_t         code_reg, code_next;
  logic [32:0]       product;
  logic signed [18:0] sum;

  // --------------------------------------------------------------------
  // Gain, offset and clamp
  // --------------------------------------------------------------------
  always_comb begin
    product = 33'(data) * 33'({1'b0, gain} + 17'h00001);
    sum     = $signed({2'b00, product[32:16]}) + $signed({3'b000, offset})
              - `QDW_OFFSET_BIAS;
    if (sum < 19'sh00000) begin
      code_next = 16'h0000;
    end else if (sum > `QDW_CODE_MAX) begin
      code_next = 16'hffff;
    end else begin
      code_next = sum[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_reg <= 16'h0000;
    end else begin
      code_reg <= code_next;
    end
  end

  assign code = code_reg;
endmodule

/* File: design/qdw_decoder.sv */
/*
  Write decoder of a quad current-output converter. Takes serial command
  frames, checks the chip address, routes data, gain, offset and clear
  codes to the channels and passes control writes on to the control path.
  Assumes CLK is the serial clock, all inputs synchronous to it, and a
  host that sends whole frames MSB first while SYNC_N is low.
*/
`timescale 1ns/1ps
`include "qdw_consts.svh"

module qdw_decoder #(
  parameter int NUM_CH = 4,   // Channels served by the two channel bits
  parameter int CODE_W = 16   // Converter code width
) (
  CLK,
  RST_N,
  SYNC_N,
  SDIN,
  FRAME_CHECK_EN,
  CHIP_ADDR_STRAP_HI,
  CHIP_ADDR_STRAP_LO,
  CLEAR_IN,
  OUT_CODE,
  CLEAR_EN_STATE,
  FRAME_ACCEPT,
  CTRL_WR,
  CTRL_SUBSEL,
  CTRL_CHAN,
  CTRL_DATA
);
  import qdw_pkg::*;

  input  wire logic                     CLK;                 // Serial clock, 20 MHz
  input  wire logic                     RST_N;               // Synchronous reset, active low
  input  wire logic                     SYNC_N;              // Frame select, active low
  input  wire logic                     SDIN;                // Serial data in
  input  wire logic                     FRAME_CHECK_EN;      // Frames carry a check byte
  input  wire logic                     CHIP_ADDR_STRAP_HI;  // Address strap, high bit
  input  wire logic                     CHIP_ADDR_STRAP_LO;  // Address strap, low bit
  input  wire logic                     CLEAR_IN;            // External clear, active high
  output qdw_pkg::qdw_code_t            OUT_CODE [4];        // Output code per channel
  output logic [3:0]                    CLEAR_EN_STATE;      // Clear enable per channel
  output logic                          FRAME_ACCEPT;        // Pulse, write frame taken
  output logic                          CTRL_WR;             // Pulse, control write
  output qdw_pkg::qdw_sel_t             CTRL_SUBSEL;         // Control register select
  output qdw_pkg::qdw_chan_t            CTRL_CHAN;           // Control channel select
  output qdw_pkg::qdw_ctrl_data_t       CTRL_DATA;           // Control data bits

  // --------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------
  if (NUM_CH != 4 || CODE_W != 16) begin : g_bad_param
    $error("qdw_decoder serves exactly four 16-bit channels");
  end

  // --------------------------------------------------------------------
  // Frame receiver
  // --------------------------------------------------------------------
  qdw_word_t frame_word;
  logic      frame_valid;

  qdw_frame_rx u_rx (
    .clk         (CLK),
    .rst_n       (RST_N),
    .sync_n      (SYNC_N),
    .sdin        (SDIN),
    .check_en    (FRAME_CHECK_EN),
    .frame_word  (frame_word),
    .frame_valid (frame_valid)
  );

  // --------------------------------------------------------------------
  // Frame fields
  // --------------------------------------------------------------------
  logic      is_write;
  logic      addr_match;
  logic      take;
  qdw_sel_t  reg_select;
  qdw_chan_t chan_sel;
  qdw_code_t data_field;
  logic      reg_select_bit2;
  logic      reg_select_bit1;
  logic      reg_select_bit0;
  logic      channel_select_hi;
  logic      channel_select_lo;
  logic      chip_addr_field_hi;
  logic      chip_addr_field_lo;

  always_comb begin
    chip_addr_field_hi = frame_word[`QDW_CHIP_HI_BIT];
    chip_addr_field_lo = frame_word[`QDW_CHIP_LO_BIT];
    reg_select_bit2    = frame_word[`QDW_REGSEL_MSB];
    reg_select_bit1    = frame_word[`QDW_REGSEL_MSB - 1];
    reg_select_bit0    = frame_word[`QDW_REGSEL_LSB];
    channel_select_hi  = frame_word[`QDW_CHSEL_MSB];
    channel_select_lo  = frame_word[`QDW_CHSEL_LSB];
    is_write   = ~frame_word[`QDW_RW_BIT];
    addr_match = (chip_addr_field_hi == CHIP_ADDR_STRAP_HI)
               & (chip_addr_field_lo == CHIP_ADDR_STRAP_LO);
    take       = frame_valid & is_write & addr_match;
    reg_select = {reg_select_bit2, reg_select_bit1, reg_select_bit0};
    chan_sel   = {channel_select_hi, channel_select_lo};
    data_field = frame_word[`QDW_DATA_MSB:`QDW_DATA_LSB];
  end

  // --------------------------------------------------------------------
  // Channel registers and control pass-through
  // --------------------------------------------------------------------
  qdw_code_t      data_reg   [4];
  qdw_code_t      data_next  [4];
  qdw_code_t      gain_reg   [4];
  qdw_code_t      gain_next  [4];
  qdw_code_t      offset_reg [4];
  qdw_code_t      offset_next[4];
  qdw_code_t      clear_reg  [4];
  qdw_code_t      clear_next [4];
  qdw_code_t      out_reg    [4];
  qdw_code_t      out_next   [4];
  qdw_code_t      calc_code  [4];
  logic [3:0]     clr_en_reg,  clr_en_next;
  logic           accept_reg,  accept_next;
  logic           ctrl_wr_reg, ctrl_wr_next;
  qdw_sel_t       subsel_reg,  subsel_next;
  qdw_chan_t      cchan_reg,   cchan_next;
  qdw_ctrl_data_t cdata_reg,   cdata_next;

  always_comb begin
    data_next    = data_reg;
    gain_next    = gain_reg;
    offset_next  = offset_reg;
    clear_next   = clear_reg;
    clr_en_next  = clr_en_reg;
    accept_next  = take;
    ctrl_wr_next = 1'b0;
    subsel_next  = subsel_reg;
    cchan_next   = cchan_reg;
    cdata_next   = cdata_reg;
    if (take) begin
      unique case (reg_select)
        `QDW_SEL_DATA: begin
          data_next[chan_sel] = data_field;
        end
        `QDW_SEL_GAIN: begin
          gain_next[chan_sel] = data_field;
        end
        `QDW_SEL_GAIN_ALL: begin
          for (int i = 0; i < 4; i++) begin
            gain_next[i] = data_field;
          end
        end
        `QDW_SEL_OFFSET: begin
          offset_next[chan_sel] = data_field;
        end
        `QDW_SEL_OFFSET_ALL: begin
          for (int i = 0; i < 4; i++) begin
            offset_next[i] = data_field;
          end
        end
        `QDW_SEL_CLEAR: begin
          clear_next[chan_sel] = data_field;
        end
        `QDW_SEL_CONTROL: begin
          ctrl_wr_next = 1'b1;
          subsel_next  = frame_word[`QDW_SUBSEL_MSB:`QDW_SUBSEL_LSB];
          cchan_next   = chan_sel;
          cdata_next   = frame_word[`QDW_CTRL_DATA_MSB:0];
          if (frame_word[`QDW_SUBSEL_MSB:`QDW_SUBSEL_LSB] == `QDW_SUBSEL_CHAN_CTRL) begin
            clr_en_next[chan_sel] = frame_word[`QDW_CLR_EN_BIT];
          end
        end
        default: begin
          accept_next = take;
        end
      endcase
    end
    // Clear outranks a data write landing in the same cycle
    for (int i = 0; i < 4; i++) begin
      if (CLEAR_IN && clr_en_reg[i]) begin
        data_next[i] = clear_reg[i];
      end
    end
  end

  // --------------------------------------------------------------------
  // Output codes
  // --------------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_chan
    qdw_out_calc u_calc (
      .clk    (CLK),
      .rst_n  (RST_N),
      .data   (data_reg[g]),
      .gain   (gain_reg[g]),
      .offset (offset_reg[g]),
      .code   (calc_code[g])
    );

    always_comb begin
      out_next[g] = (CLEAR_IN && clr_en_reg[g]) ? clear_reg[g] : calc_code[g];
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < 4; i++) begin
        data_reg[i]   <= `QDW_DATA_RST;
        gain_reg[i]   <= `QDW_GAIN_RST;
        offset_reg[i] <= `QDW_OFFSET_RST;
        clear_reg[i]  <= `QDW_CLEAR_RST;
        out_reg[i]    <= 16'h0000;
      end
      clr_en_reg  <= 4'h0;
      accept_reg  <= 1'b0;
      ctrl_wr_reg <= 1'b0;
      subsel_reg  <= 3'h0;
      cchan_reg   <= 2'h0;
      cdata_reg   <= 13'h0000;
    end else begin
      data_reg    <= data_next;
      gain_reg    <= gain_next;
      offset_reg  <= offset_next;
      clear_reg   <= clear_next;
      out_reg     <= out_next;
      clr_en_reg  <= clr_en_next;
      accept_reg  <= accept_next;
      ctrl_wr_reg <= ctrl_wr_next;
      subsel_reg  <= subsel_next;
      cchan_reg   <= cchan_next;
      cdata_reg   <= cdata_next;
    end
  end

  // --------------------------------------------------------------------
  // Port drive
  // --------------------------------------------------------------------
  assign OUT_CODE       = out_reg;
  assign CLEAR_EN_STATE = clr_en_reg;
  assign FRAME_ACCEPT   = accept_reg;
  assign CTRL_WR        = ctrl_wr_reg;
  assign CTRL_SUBSEL    = subsel_reg;
  assign CTRL_CHAN      = cchan_reg;
  assign CTRL_DATA      = cdata_reg;
endmodule

/* File: testbench/qdw_decoder_asserts.sv */
/*
  Port checker of the write decoder, bound to qdw_decoder.
  Assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "qdw_consts.svh"

module qdw_decoder_asserts (
  input wire logic               CLK,             // Serial clock
  input wire logic               RST_N,           // Reset, active low
  input wire logic               SYNC_N,          // Frame select
  input wire logic               CLEAR_IN,        // External clear
  input qdw_pkg::qdw_code_t      OUT_CODE [4],    // Output codes
  input wire logic [3:0]         CLEAR_EN_STATE,  // Clear enables
  input wire logic               FRAME_ACCEPT,    // Frame taken
  input wire logic               CTRL_WR,         // Control write
  input qdw_pkg::qdw_sel_t       CTRL_SUBSEL,     // Control select
  input qdw_pkg::qdw_chan_t      CTRL_CHAN,       // Control channel
  input qdw_pkg::qdw_ctrl_data_t CTRL_DATA        // Control data
);
  import qdw_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_accept_close;
    FRAME_ACCEPT |-> $past(SYNC_N, 2) && !$past(SYNC_N, 3);
  endproperty
  a_accept_close: assert property (p_accept_close) else $error("accept off frame close");

  property p_accept_pulse;
    FRAME_ACCEPT |=> !FRAME_ACCEPT;
  endproperty
  a_accept_pulse: assert property (p_accept_pulse) else $error("accept too long");

  property p_ctrl_in_accept;
    CTRL_WR |-> FRAME_ACCEPT;
  endproperty
  a_ctrl_in_accept: assert property (p_ctrl_in_accept) else $error("control write alone");

  property p_ctrl_hold;
    !CTRL_WR && !$past(CTRL_WR) |-> $stable(CTRL_DATA) && $stable(CTRL_SUBSEL)
      && $stable(CTRL_CHAN);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control fields moved");

  property p_clear_en_cause;
    $changed(CLEAR_EN_STATE) |-> (CTRL_WR || $past(CTRL_WR))
      && CTRL_SUBSEL == `QDW_SUBSEL_CHAN_CTRL;
  endproperty
  a_clear_en_cause: assert property (p_clear_en_cause) else $error("clear enable moved");

  property p_clear_hold;
    CLEAR_IN && $past(CLEAR_IN) && CLEAR_EN_STATE[0] |=> $stable(OUT_CODE[0]);
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("output moved in clear");

  property p_out_cause;
    $changed(OUT_CODE[1]) |-> $past(FRAME_ACCEPT, 2) || $past(CLEAR_IN)
      || $past(CLEAR_IN, 2) || $past(CLEAR_IN, 3);
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("output moved uncaused");

  property p_reset_out;
    $rose(RST_N) |-> OUT_CODE[0] == 16'h0000 && OUT_CODE[3] == 16'h0000
      && CLEAR_EN_STATE == 4'h0 && !FRAME_ACCEPT;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("bad reset outputs");
endmodule

bind qdw_decoder qdw_decoder_asserts u_chk (
  .CLK(CLK), .RST_N(RST_N), .SYNC_N(SYNC_N), .CLEAR_IN(CLEAR_IN),
  .OUT_CODE(OUT_CODE), .CLEAR_EN_STATE(CLEAR_EN_STATE), .FRAME_ACCEPT(FRAME_ACCEPT),
  .CTRL_WR(CTRL_WR), .CTRL_SUBSEL(CTRL_SUBSEL), .CTRL_CHAN(CTRL_CHAN),
  .CTRL_DATA(CTRL_DATA)
);

/* File: testbench/qdw_host.sv */
/*
  Host controller model: sends whole serial frames, MSB first.
  Assumes the bench calls send from its main sequence.
*/
`timescale 1ns/1ps

module qdw_host (
  input wire logic clk,     // Serial clock
  output logic     sync_n,  // Frame select, active low
  output logic     sdin     // Serial data
);
  initial begin
    sync_n = 1'b1;
    sdin = 1'b0;
  end

  task automatic send(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      #1;
      sync_n = 1'b0;
      sdin = w[i];
    end
    @(posedge clk);
    #1;
    sync_n = 1'b1;
    sdin = ~sdin;
    @(posedge clk);
  endtask
endmodule

/* File: testbench/tb_quad_dac_write_decoder_regs.sv */
/*
  Self-checking bench of the write decoder with a host frame model.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "qdw_consts.svh"

module tb_quad_dac_write_decoder_regs;
  import qdw_pkg::*;
  typedef struct {
    qdw_code_t      oc [4];
    logic [3:0]     ce;
    logic           ctl;
    qdw_sel_t       sub;
    qdw_chan_t      ch;
    qdw_ctrl_data_t dat;
  } qdw_note_t;

  logic           clk, rst_n, chk_en, strap_hi, strap_lo, clear_in;
  logic           sync_n, sdin, accept, ctrl_wr;
  qdw_code_t      out_code [4];
  logic [3:0]     clr_en, ce;
  qdw_sel_t       ctrl_sub, m_sub;
  qdw_chan_t      ctrl_ch, m_ch;
  qdw_ctrl_data_t ctrl_dat, m_dat;
  qdw_code_t      dat [4], gn [4], of [4], cl [4];
  qdw_note_t      notes [$];
  qdw_note_t      mon_n;
  int             bad_count, tests_run;
  logic [31:0]    seed = 32'd50;

  qdw_decoder DUT (
    .CLK(clk), .RST_N(rst_n), .SYNC_N(sync_n), .SDIN(sdin), .FRAME_CHECK_EN(chk_en),
    .CHIP_ADDR_STRAP_HI(strap_hi), .CHIP_ADDR_STRAP_LO(strap_lo), .CLEAR_IN(clear_in),
    .OUT_CODE(out_code), .CLEAR_EN_STATE(clr_en), .FRAME_ACCEPT(accept),
    .CTRL_WR(ctrl_wr), .CTRL_SUBSEL(ctrl_sub), .CTRL_CHAN(ctrl_ch), .CTRL_DATA(ctrl_dat)
  );
  qdw_host u_host (.clk(clk), .sync_n(sync_n), .sdin(sdin));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic qdw_code_t calc(input qdw_code_t d, input qdw_code_t g, input qdw_code_t o);
    logic [32:0] p;
    int          s;
    p = 33'(d) * (33'(g) + 33'h1);
    s = int'(p[32:16]) + int'(o) - 32768;
    return (s < 0) ? 16'h0000 : (s > 65535) ? 16'hffff : 16'(s);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic init_model();
    for (int i = 0; i < 4; i++) begin
      dat[i] = 16'h0000;
      gn[i] = 16'hffff;
      of[i] = 16'h8000;
      cl[i] = 16'h0000;
    end
    ce = 4'h0;
    m_sub = '0;
    m_ch = '0;
    m_dat = '0;
  endtask

  task automatic wr(input qdw_sel_t s, input qdw_chan_t c, input qdw_code_t d, input logic pc);
    qdw_note_t   n;
    logic [23:0] w;
    w = {1'b0, strap_hi, strap_lo, s, c, d};
    case (s)
      3'h0: dat[c] = d;
      3'h2: gn[c] = d;
      3'h3: gn = '{d, d, d, d};
      3'h4: of[c] = d;
      3'h5: of = '{d, d, d, d};
      3'h6: cl[c] = d;
      3'h7: begin
        m_sub = d[15:13];
        m_ch = c;
        m_dat = d[12:0];
        if (d[15:13] == 3'h2) ce[c] = d[6];
      end
      default: ;
    endcase
    for (int i = 0; i < 4; i++) n.oc[i] = calc(dat[i], gn[i], of[i]);
    n.ce = ce;
    n.ctl = (s == 3'h7);
    n.sub = m_sub;
    n.ch = m_ch;
    n.dat = m_dat;
    notes.push_back(n);
    #1;
    chk_en = pc;
    if (pc) u_host.send({w, 8'(rnd())}, 32);
    else u_host.send(32'(w), 24);
    repeat (4) @(posedge clk);
  endtask

  always @(negedge clk) begin
    if (rst_n === 1'b1 && accept === 1'b1) begin
      if (notes.size() == 0) begin
        bad_count++;
        $display("[FAIL] %0t unexpected accept", $time);
      end else begin
        mon_n = notes.pop_front();
        chk(16'(ctrl_wr), 16'(mon_n.ctl));
        chk(16'(ctrl_dat), 16'(mon_n.dat));
        chk(16'({ctrl_sub, ctrl_ch}), 16'({mon_n.sub, mon_n.ch}));
        repeat (2) @(negedge clk);
        for (int i = 0; i < 4; i++) chk(out_code[i], mon_n.oc[i]);
        chk(16'(clr_en), 16'(mon_n.ce));
      end
    end
  end

  initial begin
    #(4000 * 50);
    bad_count++;
    $display("[FAIL] %0t timeout", $time);
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    chk_en = 1'b0;
    strap_hi = 1'b1;
    strap_lo = 1'b0;
    clear_in = 1'b0;
    init_model();
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    wr(3'h1, 2'h2, 16'hbeef, 1'b0);
    for (int c = 0; c < 4; c++) begin
      wr(3'h0, 2'(c), 16'(rnd()), 1'b0);
      wr(3'h2, 2'(c), 16'(rnd()) | 16'h8000, c[0]);
      wr(3'h4, 2'(c), 16'(rnd()), c[1]);
      wr(3'h6, 2'(c), 16'(rnd()), 1'b0);
    end
    wr(3'h3, 2'(rnd()), 16'hc000, 1'b0);
    wr(3'h5, 2'(rnd()), 16'h0000, 1'b0);
    wr(3'h5, 2'(rnd()), 16'hffff, 1'b0);
    wr(3'h4, 2'h3, 16'h8000, 1'b0);
    wr(3'h7, 2'h0, 16'h4040, 1'b0);
    wr(3'h7, 2'h2, 16'h5fff, 1'b1);
    wr(3'h7, 2'h1, 16'h2abc, 1'b0);
    #1 clear_in = 1'b1;
    repeat (3) @(posedge clk);
    #1 clear_in = 1'b0;
    for (int i = 0; i < 4; i++) if (ce[i]) dat[i] = cl[i];
    repeat (3) @(posedge clk);
    wr(3'h0, 2'h1, 16'h1234, 1'b0);
    u_host.send({8'h0, 1'b1, strap_hi, strap_lo, 21'h0abcd}, 24);
    u_host.send({8'h0, 1'b0, ~strap_hi, strap_lo, 21'h0abcd}, 24);
    u_host.send({9'h0, 1'b0, strap_hi, strap_lo, 20'h0abcd}, 23);
    #1 strap_lo = 1'b1;
    wr(3'h0, 2'h3, 16'(rnd()), 1'b0);
    #1 rst_n = 1'b0;
    init_model();
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    wr(3'h1, 2'h0, 16'h0f0f, 1'b0);
    repeat (6) @(posedge clk);
    chk(16'(notes.size()), 16'h0000);
    end_of_test();
  end
endmodule
